// ===== shared/stop_brake_consts.svh
`ifndef STOP_BRAKE_CONSTS_SVH
`define STOP_BRAKE_CONSTS_SVH
// Frequencies in 0.1 Hz units, times in 0.1 s units
`define FREQ_MIN 10'd5
`define FREQ_MAX 10'd600
`define TIME_OFF 11'd0
`define TIME_MAX 11'd1200
`define STRENGTH_MAX 7'd100
`define STRENGTH_STEP 7'd5
// One brake time unit is 0.1 s
`define TICK_NS 100000000
`define CLK_PERIOD_NS 50
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define FN_MULTI_SPEED 4'h0
`define FN_RESET 4'h1
`define FN_RESET_LOCK 4'h2
`define FN_INCHING 4'h3
`define FN_EXT_FAULT 4'h4
`define FN_WRITE_DISABLE 4'h5
`define FN_COAST 4'h6
`define FN_FREQ_SWITCH 4'h7
`define FN_SECOND_CHAR 4'h8
`define FN_PID_BYPASS 4'h9
`define FN_THREE_WIRE 4'hA
`define FN_SPEED_SEARCH 4'hC
`define FN_WINDING_PAUSE 4'hD
`define STOP_MODE_RAMP 1'b0
`define STOP_MODE_COAST 1'b1
`define MULTI16_MODE 3'h1
`endif

// ===== shared/stop_brake_pkg.sv
package stop_brake_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RUN = 5'b00010,
		ST_RAMP = 5'b00100,
		ST_BRAKE = 5'b01000,
		ST_STOPPED = 5'b10000
	} drive_state_t;
	typedef struct packed {
		logic [9:0] startFrequencySetting;
		logic [9:0] stopFrequencySetting;
		logic [10:0] stopBrakeTime;
		logic [6:0] stopBrakeStrength;
		logic [9:0] reversalBrakeThreshold;
		logic [10:0] reversalBrakeTime;
		logic [6:0] reversalBrakeStrength;
		logic stopModeSelect;
		logic [2:0] multiSpeedModeSelect;
	} brake_cfg_t;
	typedef struct packed {
		logic multiSpeed;
		logic inching;
		logic extFault;
		logic writeDisable;
		logic coast;
		logic freqSwitch;
		logic secondChar;
		logic pidBypass;
		logic threeWireStop;
		logic speedSearch;
		logic windingPause;
		logic resetLock;
	} input_funcs_t;
endpackage : stop_brake_pkg

// ===== core/stop_brake_and_input_select.sv
// Behaviour
// - On a run command the output starts at the start frequency, 0.5 to 60.0 Hz.
// - In ramp-to-stop the output is shut off once it reaches the stop frequency; with a non-zero stop brake time the code shuts it off once below it.
// - Falling below the stop frequency in ramp-to-stop applies DC braking.
// - The stop brake lasts the stop brake time, 0.1 to 120.0 s; zero disables it.
// - Stop brake strength is 0 to 100 in steps of 5; larger is stronger.
// - On direction change, braking starts when the output falls below the reversal threshold.
// - The reversal threshold counts only when the reversal brake time is non-zero.
// - The reversal brake lasts the reversal brake time; zero suppresses it.
// - Reversal brake strength is 0 to 100 in steps of 5; larger is stronger.
// - Each of the five inputs has its own function selector decoded to a function.
// - For 16-speed with all five on multi-speed, only inputs one to four form the command.
// - A reset input clears a present trip when it goes from ON to OFF.
// - Stop mode is ramp along the deceleration or coast with output removed at once.
`timescale 1ns/100ps
`include "stop_brake_consts.svh"
module stop_brake_and_input_select #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire stop_brake_pkg::brake_cfg_t cfg,
	input wire logic [3:0] functionSelect [5],
	input wire logic [4:0] digitalInput,
	input wire logic runCommand,
	input wire logic reverseCommand,
	input wire logic [9:0] outputFrequency,
	input wire logic faultTrip,
	output logic outputEnable,
	output logic [9:0] frequencyPreset,
	output logic presetLoad,
	output logic dcBrake,
	output logic [6:0] brakeStrength,
	output logic stoppedState,
	output logic faultClear,
	output logic [3:0] speedCommand,
	output stop_brake_pkg::input_funcs_t inputFuncs
);
	import stop_brake_pkg::*;

	drive_state_t state;
	drive_state_t next_state;
	logic [4:0] prevInput;
	logic [4:0] isMulti;
	logic [4:0] isReset;
	logic [4:0] resetFall;
	logic [10:0] brakeLeft;
	logic [$clog2(TICK_CYCLES)-1:0] tickCount;
	logic tick;
	logic lastDir;
	logic dirChange;
	logic revEnable;
	logic belowStop;
	logic belowRev;
	logic brakeDone;
	logic startBrake;
	logic startRevBrake;
	logic [3:0] next_speed;
	input_funcs_t next_funcs;

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_dec
			assign isMulti[gi] = functionSelect[gi] == `FN_MULTI_SPEED;
			assign isReset[gi] = functionSelect[gi] == `FN_RESET;
			assign resetFall[gi] = isReset[gi] && prevInput[gi] && !digitalInput[gi];
		end
	endgenerate

	function automatic logic anyFn(input logic [3:0] sel [5], input logic [4:0] din,
			input logic [3:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (sel[i] == code && din[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : anyFn

	always_comb begin
		next_funcs.multiSpeed = |(isMulti & digitalInput);
		next_funcs.inching = anyFn(functionSelect, digitalInput, `FN_INCHING);
		next_funcs.extFault = anyFn(functionSelect, digitalInput, `FN_EXT_FAULT);
		next_funcs.writeDisable = anyFn(functionSelect, digitalInput, `FN_WRITE_DISABLE);
		next_funcs.coast = anyFn(functionSelect, digitalInput, `FN_COAST);
		next_funcs.freqSwitch = anyFn(functionSelect, digitalInput, `FN_FREQ_SWITCH);
		next_funcs.secondChar = anyFn(functionSelect, digitalInput, `FN_SECOND_CHAR);
		next_funcs.pidBypass = anyFn(functionSelect, digitalInput, `FN_PID_BYPASS);
		next_funcs.threeWireStop = anyFn(functionSelect, digitalInput, `FN_THREE_WIRE);
		next_funcs.speedSearch = anyFn(functionSelect, digitalInput, `FN_SPEED_SEARCH);
		next_funcs.windingPause = anyFn(functionSelect, digitalInput, `FN_WINDING_PAUSE);
		next_funcs.resetLock = anyFn(functionSelect, digitalInput, `FN_RESET_LOCK);
	end

	assign next_speed = (&isMulti && cfg.multiSpeedModeSelect == `MULTI16_MODE)
		? digitalInput[3:0] : (digitalInput[3:0] & isMulti[3:0]);

	assign tick = tickCount == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
	assign dirChange = (state == ST_RUN) && (reverseCommand != lastDir);
	assign revEnable = cfg.reversalBrakeTime != `TIME_OFF;
	assign belowStop = outputFrequency < cfg.stopFrequencySetting;
	assign belowRev = revEnable && outputFrequency < cfg.reversalBrakeThreshold;
	assign startBrake = belowStop && cfg.stopBrakeTime != `TIME_OFF;
	assign startRevBrake = dirChange && belowRev;
	// Last tick ends the brake, so it lasts exactly the set time
	assign brakeDone = brakeLeft == `TIME_OFF || (brakeLeft == 11'h001 && tick);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE, ST_STOPPED: begin
				if (runCommand && !faultTrip) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (faultTrip) begin
					next_state = ST_STOPPED;
				end else if (!runCommand || next_funcs.coast) begin
					next_state = (cfg.stopModeSelect == `STOP_MODE_COAST || next_funcs.coast)
						? ST_STOPPED : ST_RAMP;
				end else if (startRevBrake) begin
					next_state = ST_BRAKE;
				end
			end
			ST_RAMP: begin
				if (faultTrip) begin
					next_state = ST_STOPPED;
				end else if (runCommand) begin
					next_state = ST_RUN;
				end else if (startBrake) begin
					next_state = ST_BRAKE;
				end else if (cfg.stopBrakeTime == `TIME_OFF
						&& outputFrequency <= cfg.stopFrequencySetting) begin
					// Only without a brake, else exact stop freq would skip it
					// shut off at stop frequency
					next_state = ST_STOPPED;
				end
			end
			ST_BRAKE: begin
				if (faultTrip) begin
					next_state = ST_STOPPED;
				end else if (brakeDone) begin
					next_state = runCommand ? ST_RUN : ST_STOPPED;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			prevInput <= 5'h00;
			lastDir <= 1'b0;
			tickCount <= '0;
		end else begin
			state <= next_state;
			prevInput <= digitalInput;
			tickCount <= (tick || state != ST_BRAKE) ? '0 : tickCount + 1'b1;
			// Old direction held in RUN with a non-zero reversal brake time until the reversal brake starts
			if (state != ST_RUN || !revEnable) begin
				lastDir <= reverseCommand;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			brakeLeft <= `TIME_OFF;
			brakeStrength <= 7'h00;
		end else if (state == ST_RAMP && next_state == ST_BRAKE) begin
			brakeLeft <= cfg.stopBrakeTime;
			brakeStrength <= cfg.stopBrakeStrength;
		end else if (state == ST_RUN && next_state == ST_BRAKE) begin
			brakeLeft <= cfg.reversalBrakeTime;
			brakeStrength <= cfg.reversalBrakeStrength;
		end else if (state == ST_BRAKE && tick && !brakeDone) begin
			brakeLeft <= brakeLeft - 11'd1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			outputEnable <= 1'b0;
			dcBrake <= 1'b0;
			stoppedState <= 1'b1;
			presetLoad <= 1'b0;
			frequencyPreset <= `FREQ_MIN;
			faultClear <= 1'b0;
			speedCommand <= 4'h0;
			inputFuncs <= '0;
		end else begin
			outputEnable <= next_state == ST_RUN || next_state == ST_RAMP;
			dcBrake <= next_state == ST_BRAKE;
			stoppedState <= next_state == ST_IDLE || next_state == ST_STOPPED;
			presetLoad <= next_state == ST_RUN && state != ST_RUN && state != ST_RAMP;
			frequencyPreset <= cfg.startFrequencySetting;
			// clear trip on ON to OFF
			faultClear <= faultTrip && |resetFall && !next_funcs.resetLock;
			speedCommand <= next_speed;
			inputFuncs <= next_funcs;
		end
	end

	property p_coast_off;
		@(posedge mclk) disable iff (!rst_n)
		(state == ST_RUN && !faultTrip && runCommand && next_funcs.coast) |=> !outputEnable;
	endproperty
	a_coast_off: assert property (p_coast_off) else $error("coast left output on");

	property p_reset_fall;
		@(posedge mclk) disable iff (!rst_n)
		(faultTrip && |resetFall && !next_funcs.resetLock) |=> faultClear;
	endproperty
	a_reset_fall: assert property (p_reset_fall) else $error("trip not cleared");

	property p_no_clear_rise;
		@(posedge mclk) disable iff (!rst_n)
		(resetFall == 5'h00) |=> !faultClear;
	endproperty
	a_no_clear_rise: assert property (p_no_clear_rise) else $error("spurious clear");

	property p_brake_off;
		@(posedge mclk) disable iff (!rst_n)
		dcBrake |-> !outputEnable;
	endproperty
	a_brake_off: assert property (p_brake_off) else $error("brake with output");

	property p_zero_time;
		@(posedge mclk) disable iff (!rst_n)
		(state == ST_RAMP && cfg.stopBrakeTime == `TIME_OFF) |=> !dcBrake;
	endproperty
	a_zero_time: assert property (p_zero_time) else $error("brake with zero time");

	property p_rev_gate;
		@(posedge mclk) disable iff (!rst_n)
		(state == ST_RUN && !revEnable) |=> state != ST_BRAKE;
	endproperty
	a_rev_gate: assert property (p_rev_gate) else $error("reversal brake ungated");

	property p_stay_stopped;
		@(posedge mclk) disable iff (!rst_n)
		(state == ST_STOPPED && !runCommand) |=> stoppedState && !outputEnable;
	endproperty
	a_stay_stopped: assert property (p_stay_stopped) else $error("left stopped state");

	property p_start_freq;
		@(posedge mclk) disable iff (!rst_n)
		(state == ST_IDLE && runCommand && !faultTrip)
			|=> presetLoad && frequencyPreset == $past(cfg.startFrequencySetting);
	endproperty
	a_start_freq: assert property (p_start_freq) else $error("bad start preset");

	property p_speed16;
		@(posedge mclk) disable iff (!rst_n)
		(&isMulti && cfg.multiSpeedModeSelect == `MULTI16_MODE)
			|=> speedCommand == $past(digitalInput[3:0]);
	endproperty
	a_speed16: assert property (p_speed16) else $error("bad 16-speed command");
endmodule : stop_brake_and_input_select

// ===== bench/drive_stage_model.sv
`timescale 1ns/100ps
module drive_stage_model (
	input wire logic mclk,
	input wire logic outputEnable,
	input wire logic presetLoad,
	input wire logic [9:0] frequencyPreset,
	input wire logic [9:0] target,
	output logic [9:0] outputFrequency
);
	initial outputFrequency = 10'h000;
	always @(posedge mclk) begin
		if (presetLoad) begin
			outputFrequency <= frequencyPreset;
		end else if (!outputEnable) begin
			outputFrequency <= 10'h000;
		end else if (outputFrequency > target) begin
			outputFrequency <= outputFrequency - 10'h001;
		end else if (outputFrequency < target) begin
			outputFrequency <= outputFrequency + 10'h001;
		end
	end
endmodule : drive_stage_model

// ===== bench/stop_brake_and_input_select_tb.sv
`timescale 1ns/100ps
module stop_brake_and_input_select_tb;
	import stop_brake_pkg::*;
	localparam int TK = 4;
	logic mclk = 0, rst_n = 0, runCommand = 0, reverseCommand = 0, faultTrip = 0;
	brake_cfg_t cfg;
	logic [3:0] functionSelect [5];
	logic [4:0] digitalInput = 5'h00;
	logic [9:0] target = 10'h000, outputFrequency, frequencyPreset;
	logic outputEnable, presetLoad, dcBrake, stoppedState, faultClear, seen;
	logic [6:0] brakeStrength;
	logic [3:0] speedCommand;
	input_funcs_t inputFuncs;
	int err_total = 0, cmp_count = 0, n;
	stop_brake_and_input_select #(.TICK_CYCLES(TK)) stop_brake_and_input_select_inst (
		.mclk, .rst_n, .cfg, .functionSelect, .digitalInput, .runCommand,
		.reverseCommand, .outputFrequency, .faultTrip, .outputEnable, .frequencyPreset,
		.presetLoad, .dcBrake, .brakeStrength, .stoppedState, .faultClear,
		.speedCommand, .inputFuncs);
	drive_stage_model drive_stage_model_inst (.mclk, .outputEnable, .presetLoad,
		.frequencyPreset, .target, .outputFrequency);
	initial forever #25 mclk = ~mclk;
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#5;
	endtask : tick
	task automatic waitOn(ref logic sig, input string what);
		n = 0;
		while (sig !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		chk(what, 16'(n < 300), 16'h1);
	endtask : waitOn
	task automatic brakeLen(input int exp);
		n = 0;
		while (dcBrake === 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		chk("brake cycles", 16'(n), 16'(exp));
	endtask : brakeLen
	task automatic results;
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	function automatic input_funcs_t expFuncs(input logic [3:0] c);
		input_funcs_t f;
		f = '0;
		case (c)
			4'h0: f.multiSpeed = 1'b1;
			4'h2: f.resetLock = 1'b1;
			4'h3: f.inching = 1'b1;
			4'h4: f.extFault = 1'b1;
			4'h5: f.writeDisable = 1'b1;
			4'h6: f.coast = 1'b1;
			4'h7: f.freqSwitch = 1'b1;
			4'h8: f.secondChar = 1'b1;
			4'h9: f.pidBypass = 1'b1;
			4'hA: f.threeWireStop = 1'b1;
			4'hC: f.speedSearch = 1'b1;
			4'hD: f.windingPause = 1'b1;
			default: f = '0;
		endcase
		return f;
	endfunction : expFuncs
	task automatic testStartReversal;
		runCommand = 1'b1;
		target = 10'h064;
		tick(1);
		chk("presetLoad", 16'(presetLoad), 16'h1);
		chk("frequencyPreset", 16'(frequencyPreset), 16'h064);
		tick(3);
		// Reverse well above the threshold, brake waits for the fall
		target = 10'h000;
		reverseCommand = 1'b1;
		waitOn(dcBrake, "reversal brake");
		chk("below threshold", 16'(outputFrequency < 10'h028), 16'h1);
		chk("rev strength", 16'(brakeStrength), 16'h19);
		brakeLen(TK);
		target = 10'h064;
		waitOn(presetLoad, "rerun");
		$display("start and reversal done");
	endtask : testStartReversal
	task automatic testRampStop;
		target = 10'h000;
		runCommand = 1'b0;
		tick(2);
		chk("ramping output", 16'(outputEnable), 16'h1);
		waitOn(dcBrake, "stop brake");
		chk("output off", 16'(outputEnable), 16'h0);
		chk("stop strength", 16'(brakeStrength), 16'h32);
		brakeLen(2 * TK);
		tick(5);
		chk("stopped", 16'({stoppedState, outputEnable}), 16'h2);
		$display("ramp stop done");
	endtask : testRampStop
	task automatic testZeroAndCoast;
		cfg.stopBrakeTime = 11'd0;
		runCommand = 1'b1;
		tick(2);
		runCommand = 1'b0;
		seen = 1'b0;
		for (int i = 0; i < 300 && stoppedState !== 1'b1; i++) begin
			tick(1);
			seen |= dcBrake;
		end
		chk("no brake", 16'(seen), 16'h0);
		chk("stop freq", 16'(outputFrequency <= 10'h01E), 16'h1);
		cfg.stopModeSelect = 1'b1;
		runCommand = 1'b1;
		tick(3);
		runCommand = 1'b0;
		tick(1);
		chk("coast off", 16'(outputEnable), 16'h0);
		cfg.stopModeSelect = 1'b0;
		// Low start so a reversal is below threshold at once
		cfg.reversalBrakeTime = 11'h000;
		cfg.startFrequencySetting = 10'h014;
		functionSelect[4] = 4'h6;
		runCommand = 1'b1;
		tick(3);
		reverseCommand = 1'b0;
		tick(2);
		chk("gated reversal", 16'({dcBrake, outputEnable}), 16'h1);
		digitalInput = 5'h10;
		tick(1);
		chk("coast input", 16'(outputEnable), 16'h0);
		runCommand = 1'b0;
		digitalInput = 5'h00;
		functionSelect[4] = 4'h0;
		tick(2);
		$display("zero time and coast done");
	endtask : testZeroAndCoast
	task automatic testFault(input logic [4:0] on, input logic exp);
		functionSelect[0] = 4'h1;
		functionSelect[1] = 4'h2;
		faultTrip = 1'b1;
		// pulse reset input ON then OFF
		digitalInput = on;
		tick(2);
		digitalInput = on & 5'h1E;
		seen = 1'b0;
		for (int i = 0; i < 3; i++) begin
			tick(1);
			seen |= faultClear;
		end
		chk("faultClear", 16'(seen), 16'(exp));
		faultTrip = 1'b0;
		digitalInput = 5'h00;
		tick(2);
		$display("fault reset done");
	endtask : testFault
	task automatic testDecode;
		logic [3:0] codes [12] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
			4'hA, 4'hC, 4'hD};
		foreach (codes[i]) begin
			for (int k = 0; k < 5; k++) functionSelect[k] = codes[i];
			digitalInput = 5'h10;
			tick(2);
			chk("inputFuncs", 16'(inputFuncs), 16'(expFuncs(codes[i])));
		end
		// All five on multi-speed for the 16-speed command
		for (int k = 0; k < 5; k++) functionSelect[k] = 4'h0;
		digitalInput = 5'h1A;
		tick(2);
		chk("speedCommand", 16'(speedCommand), 16'h000A);
		$display("decode done");
	endtask : testDecode
	initial begin
		cfg = '{10'd100, 10'd30, 11'd2, 7'd50, 10'd40, 11'd1, 7'd25, 1'b0, 3'h1};
		for (int k = 0; k < 5; k++) functionSelect[k] = 4'h0;
		tick(4);
		chk("reset state", 16'({stoppedState, outputEnable, dcBrake}), 16'h4);
		chk("reset preset", 16'(frequencyPreset), 16'h5);
		rst_n = 1'b1;
		tick(1);
		testStartReversal();
		testRampStop();
		testZeroAndCoast();
		testFault(5'h01, 1'b1);
		testFault(5'h03, 1'b0);
		testDecode();
		results();
	end
	initial begin
		#200000;
		err_total++;
		results();
	end
endmodule : stop_brake_and_input_select_tb
